/* rtl/tec_consts.vh */
// Behaviour
// - wave select: up, up/down, each optional C-trigger
// - trigger-enabled external event resets count, starts clock
// - event drives pin A; pin B only when output
// - source select: pin B or clock lines 0-2
// - pin B as source becomes input, stops waveform
// - edge select: none, rising, falling, both
// - disable-on-C bit stops clock enable at compare
// - stop-on-C bit stops counter clock at compare
`ifndef TEC_CONSTS_VH
`define TEC_CONSTS_VH

`define TEC_ADDR_W 4
`define TEC_CNT_W 16

`define TEC_OFS_CTRL 4'h0
`define TEC_OFS_MODE 4'h4
`define TEC_OFS_CMPC 4'h8
`define TEC_OFS_COUNT 4'hC

`define TEC_CTRL_CLKEN 0
`define TEC_CTRL_CLKDIS 1
`define TEC_CTRL_SWTRG 2

`define TEC_MODE_WAVE_HI 14
`define TEC_MODE_WAVE_LO 13
`define TEC_MODE_TRGEN 12
`define TEC_MODE_SRC_HI 11
`define TEC_MODE_SRC_LO 10
`define TEC_MODE_EDGE_HI 9
`define TEC_MODE_EDGE_LO 8
`define TEC_MODE_CDIS 7
`define TEC_MODE_CSTOP 6
`define TEC_MODE_RESET 32'h00000000
`define TEC_MODE_MASK 32'h00007FC0

`define TEC_STAT_OFS 4'h0
`define TEC_OFS_STAT 4'h0

`define TEC_WAVE_UP 2'h0
`define TEC_WAVE_BIDIRECTIONAL_COUNT 2'h1
`define TEC_WAVE_UP_C 2'h2
`define TEC_WAVE_BIDIRECTIONAL_COUNT_C 2'h3

`define TEC_SRC_PIN_B 2'h0
`define TEC_SRC_LINE0 2'h1
`define TEC_SRC_LINE1 2'h2
`define TEC_SRC_LINE2 2'h3

`define TEC_EDGE_NONE 2'h0
`define TEC_EDGE_RISE 2'h1
`define TEC_EDGE_FALL 2'h2
`define TEC_EDGE_BOTH 2'h3

`define TEC_CNT_MAX 16'hFFFF
`define TEC_CNT_ZERO 16'h0000

`endif

/* rtl/tec_edge_det.v */
`include "tec_consts.vh"
`default_nettype none

module tec_edge_det (
  input wire core_clk,
  input wire rst,
  input wire sig_in,
  input wire [1:0] edge_sel,
  output reg event_pulse
);
  reg prev_ff;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= sig_in;
    end
  end

  always @* begin
    case (edge_sel)
      `TEC_EDGE_NONE: event_pulse = 1'b0;
      `TEC_EDGE_RISE: event_pulse = sig_in & ~prev_ff;
      `TEC_EDGE_FALL: event_pulse = ~sig_in & prev_ff;
      `TEC_EDGE_BOTH: event_pulse = sig_in ^ prev_ff;
      default: event_pulse = 1'b0;
    endcase
  end
endmodule // tec_edge_det

`default_nettype wire

/* rtl/tec_ctrl.v */
`include "tec_consts.vh"
`default_nettype none

module tec_ctrl (
  input wire core_clk,
  input wire rst,
  input wire [`TEC_ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire ext_clock_line_0,
  input wire ext_clock_line_1,
  input wire ext_clock_line_2,
  input wire waveform_pin_b_in,
  output reg waveform_pin_b_out,
  output reg waveform_pin_b_oe,
  output reg waveform_pin_a
);
  // software registers
  reg [1:0] wave_sel_ff;
  reg ext_event_trigger_enable_ff;
  reg [1:0] ext_event_source_select_ff;
  reg [1:0] ext_event_edge_select_ff;
  reg clock_disable_on_c_compare_ff;
  reg clock_stop_on_c_compare_ff;
  reg [`TEC_CNT_W-1:0] compare_c_value_ff;

  // counter state
  reg [`TEC_CNT_W-1:0] count_ff;
  reg [`TEC_CNT_W-1:0] nxt_count;
  reg down_ff;
  reg nxt_down;
  reg clk_en_ff;
  reg run_ff;
  reg ack_ff;

  wire req = avs_read | avs_write;
  // the write lands on the edge where the master sees waitrequest low
  wire wr_take = avs_write & ack_ff;
  wire wr_ctrl = wr_take & (avs_address == `TEC_OFS_CTRL);
  wire wr_mode = wr_take & (avs_address == `TEC_OFS_MODE);
  wire wr_cmpc = wr_take & (avs_address == `TEC_OFS_CMPC);

  wire pin_b_is_input = (ext_event_source_select_ff == `TEC_SRC_PIN_B);
  wire counting = clk_en_ff & run_ff;
  wire c_hit = counting & (count_ff == compare_c_value_ff);
  wire c_trig_mode = wave_sel_ff[1];
  wire bidirectional_count_mode = wave_sel_ff[0];

  reg event_src;
  wire ext_event;

  always @* begin
    case (ext_event_source_select_ff)
      `TEC_SRC_PIN_B: event_src = waveform_pin_b_in;
      `TEC_SRC_LINE0: event_src = ext_clock_line_0;
      `TEC_SRC_LINE1: event_src = ext_clock_line_1;
      `TEC_SRC_LINE2: event_src = ext_clock_line_2;
      default: event_src = 1'b0;
    endcase
  end

  tec_edge_det u_edge (
    .core_clk(core_clk),
    .rst(rst),
    .sig_in(event_src),
    .edge_sel(ext_event_edge_select_ff),
    .event_pulse(ext_event)
  );

  wire sw_trig = wr_ctrl & avs_writedata[`TEC_CTRL_SWTRG];
  wire ev_trig = ext_event & ext_event_trigger_enable_ff;
  wire cmd_trig = sw_trig | ev_trig;
  // in up mode with C-trigger a C match restarts the count like a trigger
  wire c_trig = c_hit & c_trig_mode & ~bidirectional_count_mode;

  // up/down turns at C when the C-trigger mode is chosen
  wire [`TEC_CNT_W-1:0] top = c_trig_mode ? compare_c_value_ff :
                              `TEC_CNT_MAX;

  always @* begin
    nxt_count = count_ff;
    nxt_down = down_ff;
    if (cmd_trig) begin
      nxt_count = `TEC_CNT_ZERO;
      nxt_down = 1'b0;
    end else if (counting) begin
      if (!bidirectional_count_mode) begin
        if (c_trig) begin
          nxt_count = `TEC_CNT_ZERO;
        end else begin
          nxt_count = count_ff + 16'h0001;
        end
      end else if (!down_ff) begin
        if (count_ff == top) begin
          nxt_down = 1'b1;
          nxt_count = count_ff - 16'h0001;
        end else begin
          nxt_count = count_ff + 16'h0001;
        end
      end else begin
        if (count_ff == `TEC_CNT_ZERO) begin
          nxt_down = 1'b0;
          nxt_count = count_ff + 16'h0001;
        end else begin
          nxt_count = count_ff - 16'h0001;
        end
      end
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count_ff <= `TEC_CNT_ZERO;
      down_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      down_ff <= nxt_down;
    end
  end

  // clock enable: disable beats enable, as a safe stop should
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clk_en_ff <= 1'b0;
    end else if (wr_ctrl & avs_writedata[`TEC_CTRL_CLKDIS]) begin
      clk_en_ff <= 1'b0;
    end else if (c_hit & clock_disable_on_c_compare_ff) begin
      clk_en_ff <= 1'b0;
    end else if (wr_ctrl & avs_writedata[`TEC_CTRL_CLKEN]) begin
      clk_en_ff <= 1'b1;
    end
  end

  // run: a trigger starts the clock, a C stop halts it; the trigger
  // wins so an event on the stopping edge is not lost
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      run_ff <= 1'b0;
    end else if (cmd_trig) begin
      run_ff <= 1'b1;
    end else if (c_hit & clock_stop_on_c_compare_ff) begin
      run_ff <= 1'b0;
    end
  end

  // waveform outputs: every selected event toggles pin A, and pin B when it is an output
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      waveform_pin_a <= 1'b0;
      waveform_pin_b_out <= 1'b0;
      waveform_pin_b_oe <= 1'b0;
    end else begin
      waveform_pin_b_oe <= ~pin_b_is_input;
      if (ext_event) begin
        waveform_pin_a <= ~waveform_pin_a;
      end
      if (ext_event & ~pin_b_is_input) begin
        waveform_pin_b_out <= ~waveform_pin_b_out;
      end else if (pin_b_is_input) begin
        waveform_pin_b_out <= 1'b0;
      end
    end
  end

  // mode and compare registers
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wave_sel_ff <= `TEC_WAVE_UP;
      ext_event_trigger_enable_ff <= 1'b0;
      ext_event_source_select_ff <= `TEC_SRC_PIN_B;
      ext_event_edge_select_ff <= `TEC_EDGE_NONE;
      clock_disable_on_c_compare_ff <= 1'b0;
      clock_stop_on_c_compare_ff <= 1'b0;
      compare_c_value_ff <= `TEC_CNT_ZERO;
    end else begin
      if (wr_mode) begin
        wave_sel_ff <=
          avs_writedata[`TEC_MODE_WAVE_HI:`TEC_MODE_WAVE_LO];
        ext_event_trigger_enable_ff <=
          avs_writedata[`TEC_MODE_TRGEN];
        ext_event_source_select_ff <=
          avs_writedata[`TEC_MODE_SRC_HI:`TEC_MODE_SRC_LO];
        ext_event_edge_select_ff <=
          avs_writedata[`TEC_MODE_EDGE_HI:`TEC_MODE_EDGE_LO];
        clock_disable_on_c_compare_ff <=
          avs_writedata[`TEC_MODE_CDIS];
        clock_stop_on_c_compare_ff <=
          avs_writedata[`TEC_MODE_CSTOP];
      end
      if (wr_cmpc) begin
        compare_c_value_ff <= avs_writedata[`TEC_CNT_W-1:0];
      end
    end
  end

  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h00000000;
    case (avs_address)
      `TEC_OFS_CTRL: begin
        rd_mux[0] = clk_en_ff;
        rd_mux[1] = run_ff;
        rd_mux[2] = down_ff;
        rd_mux[3] = pin_b_is_input;
      end
      `TEC_OFS_MODE: begin
        rd_mux[`TEC_MODE_WAVE_HI:`TEC_MODE_WAVE_LO] = wave_sel_ff;
        rd_mux[`TEC_MODE_TRGEN] = ext_event_trigger_enable_ff;
        rd_mux[`TEC_MODE_SRC_HI:`TEC_MODE_SRC_LO] =
          ext_event_source_select_ff;
        rd_mux[`TEC_MODE_EDGE_HI:`TEC_MODE_EDGE_LO] =
          ext_event_edge_select_ff;
        rd_mux[`TEC_MODE_CDIS] = clock_disable_on_c_compare_ff;
        rd_mux[`TEC_MODE_CSTOP] = clock_stop_on_c_compare_ff;
      end
      `TEC_OFS_CMPC: rd_mux[`TEC_CNT_W-1:0] = compare_c_value_ff;
      `TEC_OFS_COUNT: rd_mux[`TEC_CNT_W-1:0] = count_ff;
      default: rd_mux = 32'h00000000;
    endcase
  end

  // one wait cycle per access: waitrequest drops one edge after the
  // request appears and rises again on the taking edge
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_ff <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      ack_ff <= req & ~ack_ff;
      avs_waitrequest <= ~(req & ~ack_ff);
      if (req & ~ack_ff) begin
        avs_readdata <= rd_mux;
      end
    end
  end
endmodule // tec_ctrl

`default_nettype wire

/* verification/tec_pin_model.sv */
`default_nettype none
module tec_pin_model (
  input wire logic core_clk,
  input wire logic [3:0] want,
  input wire logic b_out,
  input wire logic b_oe,
  output logic b_in,
  output logic [2:0] lines
);
  timeunit 1ns;
  timeprecision 1ps;
  // lines are synchronous to the core clock, so launch them off an edge
  always_ff @(posedge core_clk) lines <= want[3:1];
  // pin B wire: the design wins while it drives, else the far side
  assign b_in = b_oe ? b_out : want[0];
endmodule // tec_pin_model
`default_nettype wire

/* verification/tec_monitor.sv */
`default_nettype none
module tec_monitor (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic ext_clock_line_0,
  input wire logic ext_clock_line_1,
  input wire logic ext_clock_line_2,
  input wire logic waveform_pin_b_in,
  input wire logic waveform_pin_b_out,
  input wire logic waveform_pin_b_oe,
  input wire logic waveform_pin_a
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] mode_ff, srcs;
  logic [1:0] age_ff;
  logic prev_ff, sel, ev, quiet, wr_mode, line_src;
  assign wr_mode = avs_write & ~avs_waitrequest & (avs_address == 4'h4);
  assign srcs = {ext_clock_line_2, ext_clock_line_1, ext_clock_line_0,
    waveform_pin_b_in};
  assign sel = srcs[mode_ff[3:2]];
  assign ev = (mode_ff[0] & sel & ~prev_ff) | (mode_ff[1] & ~sel & prev_ff);
  // settle time after reset or a mode write, old source history is stale
  assign quiet = (age_ff == 2'h3);
  assign line_src = (mode_ff[3:2] != 2'h0);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_ff <= 4'h0;
      age_ff <= 2'h0;
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= sel;
      if (wr_mode) begin
        mode_ff <= avs_writedata[11:8];
        age_ff <= 2'h0;
      end else if (!quiet) begin
        age_ff <= age_ff + 2'h1;
      end
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_to_line;
    wr_mode && avs_writedata[11:10] != 2'h0 ##1 !wr_mode ##1 !wr_mode;
  endsequence
  property p_a_toggle;
    quiet && ev |=> waveform_pin_a != $past(waveform_pin_a);
  endproperty
  property p_a_hold;
    quiet && !ev |=> $stable(waveform_pin_a);
  endproperty
  property p_b_toggle;
    quiet && ev && line_src |=>
      waveform_pin_b_out != $past(waveform_pin_b_out);
  endproperty
  property p_b_hold;
    quiet && !ev |=> $stable(waveform_pin_b_out);
  endproperty
  property p_oe_out;
    quiet && line_src |-> waveform_pin_b_oe;
  endproperty
  property p_oe_in;
    quiet && !line_src |-> !waveform_pin_b_oe;
  endproperty
  property p_in_quiet;
    quiet && !line_src |-> !waveform_pin_b_out;
  endproperty
  property p_src_switch;
    s_to_line |-> waveform_pin_b_oe;
  endproperty
  a_a_toggle: assert property (p_a_toggle) else $error("A missed");
  a_a_hold: assert property (p_a_hold) else $error("A moved");
  a_b_toggle: assert property (p_b_toggle) else $error("B missed");
  a_b_hold: assert property (p_b_hold) else $error("B moved");
  a_oe_out: assert property (p_oe_out) else $error("B not driven");
  a_oe_in: assert property (p_oe_in) else $error("B driven");
  a_in_quiet: assert property (p_in_quiet) else $error("B level");
  a_src_switch: assert property (p_src_switch) else $error("B oe");
endmodule // tec_monitor
bind tec_ctrl tec_monitor mon (
  .core_clk(core_clk),
  .rst(rst),
  .avs_address(avs_address),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_waitrequest(avs_waitrequest),
  .ext_clock_line_0(ext_clock_line_0),
  .ext_clock_line_1(ext_clock_line_1),
  .ext_clock_line_2(ext_clock_line_2),
  .waveform_pin_b_in(waveform_pin_b_in),
  .waveform_pin_b_out(waveform_pin_b_out),
  .waveform_pin_b_oe(waveform_pin_b_oe),
  .waveform_pin_a(waveform_pin_a)
);
`default_nettype wire

/* verification/timer_event_rc_compare_ctrl_bench.sv */
`default_nettype none
module timer_event_rc_compare_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0, want = 4'h0;
  logic [31:0] avs_writedata = 32'h0, rd;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, b_out, b_oe, b_in, pin_a;
  wire [2:0] lines;
  int errors = 0, cmp_count = 0, cyc = 0;
  always #5 core_clk = ~core_clk;
  tec_ctrl uut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_clock_line_0(lines[0]),
    .ext_clock_line_1(lines[1]), .ext_clock_line_2(lines[2]),
    .waveform_pin_b_in(b_in), .waveform_pin_b_out(b_out),
    .waveform_pin_b_oe(b_oe), .waveform_pin_a(pin_a));
  tec_pin_model pins (.core_clk(core_clk), .want(want), .b_out(b_out),
    .b_oe(b_oe), .b_in(b_in), .lines(lines));
  task automatic tally_and_finish;
    if (errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    tick(1);
  endtask
  task automatic do_reset;
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(1);
  endtask
  task automatic t_regs;
    do_reset();
    check(b_oe, 32'h0);
    bus(1'b1, 4'h2, 32'hFFFFFFFF);
    bus(1'b0, 4'h2, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, 4'h4, 32'hFFFFFFFF);
    bus(1'b0, 4'h4, 32'h0);
    check(rd, 32'h00007FC0);
    check(b_oe, 32'h1);
  endtask
  task automatic t_wave;
    for (int w = 0; w < 4; w++) begin
      do_reset();
      bus(1'b1, 4'h8, 32'h3);
      bus(1'b1, 4'h4, 32'(w) << 13);
      bus(1'b1, 4'h0, 32'h5);
      tick(20);
      bus(1'b0, 4'hC, 32'h0);
      check(rd > 32'h3, !w[1]);
      // 21 steps after the trigger: plain count, C wrap, or C turn
      check(rd, (w < 2) ? 32'h15 : (w == 2) ? 32'h1 : 32'h3);
    end
  endtask
  task automatic t_stop;
    for (int m = 0; m < 3; m++) begin
      do_reset();
      bus(1'b1, 4'h8, 32'h5);
      bus(1'b1, 4'h4, 32'(m) << 6);
      bus(1'b1, 4'h0, 32'h5);
      tick(20);
      bus(1'b0, 4'h0, 32'h0);
      check(rd[1:0], {~m[0], ~m[1]});
    end
  endtask
  task automatic t_event;
    for (int e = 0; e < 4; e++) begin
      logic [1:0] s;
      logic a0, b0;
      s = 2'(e + 1);
      do_reset();
      bus(1'b1, 4'h4, {19'h0, e[1], s, e[1:0], 8'h00});
      a0 = pin_a;
      b0 = b_out;
      want[s] <= 1'b1;
      tick(4);
      check(pin_a ^ a0, e[0]);
      check(b_out ^ b0, e[0] & (s != 2'h0));
      check(b_oe, s != 2'h0);
      bus(1'b0, 4'h0, 32'h0);
      check(rd[1], e[0] & e[1]);
      check(rd[3], s == 2'h0);
      a0 = pin_a;
      want[s] <= 1'b0;
      tick(4);
      check(pin_a ^ a0, e[1]);
    end
  endtask
  task automatic t_trig;
    for (int t = 0; t < 2; t++) begin
      do_reset();
      bus(1'b1, 4'h4, {19'h0, t[0], 2'h1, 2'h1, 8'h00});
      bus(1'b1, 4'h0, 32'h1);
      tick(4);
      bus(1'b0, 4'h0, 32'h0);
      check(rd[1], 1'b0);
      want[1] <= 1'b1;
      tick(3);
      bus(1'b0, 4'h0, 32'h0);
      check(rd[1], t[0]);
      want[1] <= 1'b0;
      bus(1'b1, 4'h0, 32'h4);
      tick(30);
      want[1] <= 1'b1;
      tick(3);
      bus(1'b0, 4'hC, 32'h0);
      check(rd < 32'h10, t[0]);
      want[1] <= 1'b0;
    end
  endtask
  initial begin
    t_regs();
    t_wave();
    t_stop();
    t_event();
    t_trig();
    tally_and_finish();
  end
endmodule // timer_event_rc_compare_ctrl_bench
`default_nettype wire
